// file: include/sso_defines.svh
// Purpose: Constants of the servo status output selector: offsets, fields, resets.
// Assumes: 20 MHz control clock, plain strobe register port, 8-bit byte address.
// Notes:   Config word index is mode * 3 + output.
//
// How it works
// - Three control outputs, each with a software-selected status function.
// - Each output has a polarity bit that inverts the selected function.
// - Alarm function drives transistor on when normal, off during alarm.
// - Servo ready needs power, no alarm, link up and sync together.
// - Brake release function turns transistor on when brake is released.
// - Positioning complete function turns transistor on after positioning done.
// - Speed arrival function turns transistor on when speed has arrived.
// - Torque limited function turns transistor on while torque is limited.
// - Zero speed function turns transistor on while zero speed detected.
// - Speed coincidence function turns transistor on while speeds coincide.
// - Function not applicable in active mode holds its transistor off.
`ifndef SSO_DEFINES_SVH
`define SSO_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define SSO_OFS_MODE        8'h00
`define SSO_OFS_CFG_BASE    8'h04
`define SSO_OFS_CFG_LAST    8'h24
`define SSO_OFS_IRQ_STATUS  8'h28
`define SSO_OFS_IRQ_CLEAR   8'h2C
`define SSO_OFS_IRQ_ENABLE  8'h30
`define SSO_OFS_OUT_STATE   8'h34

// ----------------------------------------------------------------------------
// Sizes and fields
// ----------------------------------------------------------------------------
`define SSO_NUM_OUT         3
`define SSO_NUM_MODE        3
`define SSO_NUM_CFG         9
`define SSO_NUM_FUNC        9
`define SSO_NUM_IRQ         5
`define SSO_CFG_FUNC_MSB    3
`define SSO_CFG_INV_BIT     4
`define SSO_IRQ_OUT_A_BIT   0
`define SSO_IRQ_ALARM_BIT   3
`define SSO_IRQ_CFGERR_BIT  4

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define SSO_RST_MODE        2'h0
`define SSO_RST_CFG_A       5'h01
`define SSO_RST_CFG_B       5'h02
`define SSO_RST_CFG_C       5'h03
`define SSO_RST_IRQ_EN      5'h00

// ----------------------------------------------------------------------------
// Applicability per function, bit0 position, bit1 velocity, bit2 torque
// ----------------------------------------------------------------------------
`define SSO_APPL_ALARM      3'h7
`define SSO_APPL_READY      3'h7
`define SSO_APPL_BRAKE      3'h7
`define SSO_APPL_POS_DONE   3'h1
`define SSO_APPL_ARRIVAL    3'h2
`define SSO_APPL_TORQUE     3'h7
`define SSO_APPL_ZERO       3'h7
`define SSO_APPL_COIN       3'h2

`endif

// file: include/sso_pkg.sv
// Purpose: Types of the servo status output selector.
// Assumes: Constants come from sso_defines.svh.
// Notes:   Function codes double as bit index into the raw function vector.
package sso_pkg;

    // ------------------------------------------------------------------------
    // Control modes
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        SSO_MODE_POS = 2'h0,
        SSO_MODE_VEL = 2'h1,
        SSO_MODE_TRQ = 2'h2,
        SSO_MODE_NONE = 2'h3
    } sso_mode_t;

    // ------------------------------------------------------------------------
    // Assignable output functions
    // ------------------------------------------------------------------------
    typedef enum logic [3:0] {
        SSO_FN_OFF      = 4'h0,
        SSO_FN_ALARM    = 4'h1,
        SSO_FN_READY    = 4'h2,
        SSO_FN_BRAKE    = 4'h3,
        SSO_FN_POS_DONE = 4'h4,
        SSO_FN_ARRIVAL  = 4'h5,
        SSO_FN_TORQUE   = 4'h6,
        SSO_FN_ZERO     = 4'h7,
        SSO_FN_COIN     = 4'h8
    } sso_func_t;

    // ------------------------------------------------------------------------
    // One output's setting for one mode
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic      invert;
        sso_func_t func;
    } sso_cfg_t;

    // ------------------------------------------------------------------------
    // Internal drive conditions, all on the control clock
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic power_ok;
        logic alarm;
        logic link_up;
        logic sync_ok;
        logic brake_release;
        logic pos_done;
        logic speed_arrived;
        logic torque_limited;
        logic zero_speed;
        logic speed_coincident;
    } sso_status_t;

endpackage

// file: src/sso_out_sel.sv
// Purpose: One control output: function pick, applicability, polarity, register.
// Assumes: Raw function vector is active high meaning transistor on.
// Notes:   Unknown function codes give transistor off.
`include "sso_defines.svh"

module sso_out_sel (
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_b_i,
    // Selection
    input  wire sso_pkg::sso_cfg_t cfg_i,
    input  wire sso_pkg::sso_mode_t mode_i,
    input  wire logic [8:0]        func_vec_i,
    // Pin drive, high means transistor on
    output logic                   out_o
);

    logic       out_r;
    logic       out_nxt;
    logic [2:0] appl;
    logic       raw;

    // Pick function and gate by active mode
    always_comb begin
        appl = 3'h0;
        raw  = 1'b0;
        case (cfg_i.func)
            sso_pkg::SSO_FN_ALARM:    appl = `SSO_APPL_ALARM;
            sso_pkg::SSO_FN_READY:    appl = `SSO_APPL_READY;
            sso_pkg::SSO_FN_BRAKE:    appl = `SSO_APPL_BRAKE;
            sso_pkg::SSO_FN_POS_DONE: appl = `SSO_APPL_POS_DONE;
            sso_pkg::SSO_FN_ARRIVAL:  appl = `SSO_APPL_ARRIVAL;
            sso_pkg::SSO_FN_TORQUE:   appl = `SSO_APPL_TORQUE;
            sso_pkg::SSO_FN_ZERO:     appl = `SSO_APPL_ZERO;
            sso_pkg::SSO_FN_COIN:     appl = `SSO_APPL_COIN;
            default:                  appl = 3'h0;
        endcase
        if (cfg_i.func <= sso_pkg::SSO_FN_COIN) begin
            raw = func_vec_i[cfg_i.func];
        end
        // Invalid mode code: nothing applies
        if (mode_i == sso_pkg::SSO_MODE_NONE || !appl[mode_i]) begin
            out_nxt = 1'b0;
        end else begin
            out_nxt = raw ^ cfg_i.invert;
        end
    end

    // Output flop, off through reset
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            out_r <= 1'b0;
        end else begin
            out_r <= out_nxt;
        end
    end

    assign out_o = out_r;

endmodule

// file: src/sso_top.sv
// Purpose: Servo status output selector with register port and interrupt.
// Assumes: Status inputs come from logic on clk_i, so no synchronisers.
// Notes:   Outputs high means the open-collector transistor is on.
`include "sso_defines.svh"

module sso_top (
    // Clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 rst_b_i,
    // Register port
    input  wire logic [7:0]           reg_addr_i,
    input  wire logic [31:0]          reg_wdata_i,
    input  wire logic                 reg_wr_i,
    input  wire logic                 reg_rd_i,
    output logic      [31:0]          reg_rdata_o,
    // Drive status conditions
    input  wire sso_pkg::sso_status_t status_i,
    // Control outputs, high is transistor on
    output logic                      ctrl_out_a_o,
    output logic                      ctrl_out_b_o,
    output logic                      ctrl_out_c_o,
    // Interrupt
    output logic                      irq_o
);

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    sso_pkg::sso_mode_t              mode_r;
    sso_pkg::sso_mode_t              mode_nxt;
    sso_pkg::sso_cfg_t [8:0]         cfg_r;
    sso_pkg::sso_cfg_t [8:0]         cfg_nxt;
    sso_pkg::sso_cfg_t [2:0]         cfg_act;
    logic [`SSO_NUM_IRQ-1:0]         irq_stat_r;
    logic [`SSO_NUM_IRQ-1:0]         irq_stat_nxt;
    logic [`SSO_NUM_IRQ-1:0]         irq_en_r;
    logic [`SSO_NUM_IRQ-1:0]         irq_en_nxt;
    logic [`SSO_NUM_IRQ-1:0]         irq_evt;
    logic [`SSO_NUM_IRQ-1:0]         irq_clr;
    logic                            irq_r;
    logic                            irq_nxt;
    logic [31:0]                     rdata_r;
    logic [31:0]                     rdata_nxt;
    logic [2:0]                      out_vec;
    logic [2:0]                      out_prev_r;
    logic                            alarm_prev_r;
    logic                            cfg_err_prev_r;
    logic [8:0]                      func_vec;
    logic [2:0]                      brake_in_mode;
    logic                            cfg_err;
    logic                            cfg_hit;
    logic [3:0]                      cfg_idx;
    logic [7:0]                      cfg_ofs;

    // ------------------------------------------------------------------------
    // Raw function conditions, high means transistor on
    // ------------------------------------------------------------------------
    // Alarm output is inverted on purpose so a dead drive reads as alarm
    assign func_vec[sso_pkg::SSO_FN_OFF]      = 1'b0;
    assign func_vec[sso_pkg::SSO_FN_ALARM]    = !status_i.alarm;
    assign func_vec[sso_pkg::SSO_FN_READY]    = status_i.power_ok && !status_i.alarm
                                                && status_i.link_up
                                                && status_i.sync_ok;
    assign func_vec[sso_pkg::SSO_FN_BRAKE]    = status_i.brake_release;
    assign func_vec[sso_pkg::SSO_FN_POS_DONE] = status_i.pos_done;
    assign func_vec[sso_pkg::SSO_FN_ARRIVAL]  = status_i.speed_arrived;
    assign func_vec[sso_pkg::SSO_FN_TORQUE]   = status_i.torque_limited;
    assign func_vec[sso_pkg::SSO_FN_ZERO]     = status_i.zero_speed;
    assign func_vec[sso_pkg::SSO_FN_COIN]     = status_i.speed_coincident;

    // ------------------------------------------------------------------------
    // Per-output selection for the active mode
    // ------------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < `SSO_NUM_OUT; g = g + 1) begin : g_out
            // Unused mode code falls back to the mode 0 word of each output; the selector blanks it anyway
            assign cfg_act[g] = (mode_r == sso_pkg::SSO_MODE_NONE) ? cfg_r[g]
                              : cfg_r[mode_r * 3 + g];
            sso_out_sel u_sel (
                .clk_i      (clk_i),
                .rst_b_i    (rst_b_i),
                .cfg_i      (cfg_act[g]),
                .mode_i     (mode_r),
                .func_vec_i (func_vec),
                .out_o      (out_vec[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Brake assignment check across modes
    // ------------------------------------------------------------------------
    // Brake output on only some modes would drop the brake on a mode change
    generate
        for (g = 0; g < `SSO_NUM_MODE; g = g + 1) begin : g_brk
            assign brake_in_mode[g] = (cfg_r[g*3].func   == sso_pkg::SSO_FN_BRAKE)
                                   || (cfg_r[g*3+1].func == sso_pkg::SSO_FN_BRAKE)
                                   || (cfg_r[g*3+2].func == sso_pkg::SSO_FN_BRAKE);
        end
    endgenerate
    assign cfg_err = (|brake_in_mode) && !(&brake_in_mode);

    // ------------------------------------------------------------------------
    // Address decode for config words
    // ------------------------------------------------------------------------
    assign cfg_hit = (reg_addr_i >= `SSO_OFS_CFG_BASE) && (reg_addr_i <= `SSO_OFS_CFG_LAST)
                     && (reg_addr_i[1:0] == 2'h0);
    assign cfg_ofs = reg_addr_i - `SSO_OFS_CFG_BASE;
    assign cfg_idx = cfg_ofs[5:2];

    // ------------------------------------------------------------------------
    // Control registers: mode, config words, interrupt enable
    // ------------------------------------------------------------------------
    always_comb begin
        mode_nxt   = mode_r;
        cfg_nxt    = cfg_r;
        irq_en_nxt = irq_en_r;
        if (reg_wr_i) begin
            if (reg_addr_i == `SSO_OFS_MODE) begin
                mode_nxt = sso_pkg::sso_mode_t'(reg_wdata_i[1:0]);
            end
            if (cfg_hit) begin
                cfg_nxt[cfg_idx] = reg_wdata_i[`SSO_CFG_INV_BIT:0];
            end
            if (reg_addr_i == `SSO_OFS_IRQ_ENABLE) begin
                irq_en_nxt = reg_wdata_i[`SSO_NUM_IRQ-1:0];
            end
        end
    end

    // Defaults give alarm, ready and brake on a, b, c in every mode
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mode_r   <= sso_pkg::sso_mode_t'(`SSO_RST_MODE);
            irq_en_r <= `SSO_RST_IRQ_EN;
            for (int i = 0; i < `SSO_NUM_MODE; i++) begin
                cfg_r[i*3]   <= `SSO_RST_CFG_A;
                cfg_r[i*3+1] <= `SSO_RST_CFG_B;
                cfg_r[i*3+2] <= `SSO_RST_CFG_C;
            end
        end else begin
            mode_r   <= mode_nxt;
            irq_en_r <= irq_en_nxt;
            cfg_r    <= cfg_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Interrupt status: set wins over clear
    // ------------------------------------------------------------------------
    always_comb begin
        irq_evt = '0;
        irq_evt[`SSO_IRQ_OUT_A_BIT +: 3] = out_vec ^ out_prev_r;
        irq_evt[`SSO_IRQ_ALARM_BIT]      = status_i.alarm && !alarm_prev_r;
        irq_evt[`SSO_IRQ_CFGERR_BIT]     = cfg_err && !cfg_err_prev_r;
        irq_clr = '0;
        if (reg_wr_i && reg_addr_i == `SSO_OFS_IRQ_CLEAR) begin
            irq_clr = reg_wdata_i[`SSO_NUM_IRQ-1:0];
        end
        // Clear first, then set, so a coincident event survives
        irq_stat_nxt = (irq_stat_r & ~irq_clr) | irq_evt;
        irq_nxt      = |(irq_stat_nxt & irq_en_nxt);
    end

    // Edge history and sticky bits
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            irq_stat_r     <= '0;
            irq_r          <= 1'b0;
            out_prev_r     <= 3'h0;
            alarm_prev_r   <= 1'b0;
            cfg_err_prev_r <= 1'b0;
        end else begin
            irq_stat_r     <= irq_stat_nxt;
            irq_r          <= irq_nxt;
            out_prev_r     <= out_vec;
            alarm_prev_r   <= status_i.alarm;
            cfg_err_prev_r <= cfg_err;
        end
    end

    // ------------------------------------------------------------------------
    // Read data, valid the cycle after the strobe only
    // ------------------------------------------------------------------------
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (reg_rd_i) begin
            if (reg_addr_i == `SSO_OFS_MODE) begin
                rdata_nxt[1:0] = mode_r;
            end
            if (cfg_hit) begin
                rdata_nxt[`SSO_CFG_INV_BIT:0] = cfg_r[cfg_idx];
            end
            if (reg_addr_i == `SSO_OFS_IRQ_STATUS) begin
                rdata_nxt[`SSO_NUM_IRQ-1:0] = irq_stat_r;
            end
            if (reg_addr_i == `SSO_OFS_IRQ_ENABLE) begin
                rdata_nxt[`SSO_NUM_IRQ-1:0] = irq_en_r;
            end
            if (reg_addr_i == `SSO_OFS_OUT_STATE) begin
                rdata_nxt[2:0] = out_vec;
                rdata_nxt[3]   = cfg_err;
            end
        end
    end

    // Read register
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_r <= 32'h0000_0000;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Output wiring, all from flops
    // ------------------------------------------------------------------------
    assign reg_rdata_o  = rdata_r;
    assign ctrl_out_a_o = out_vec[0];
    assign ctrl_out_b_o = out_vec[1];
    assign ctrl_out_c_o = out_vec[2];
    assign irq_o        = irq_r;

endmodule

// file: sim/sso_top_props.sv
// Purpose: Port-level checks of the status output selector.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes:   Sees only the top ports; the bind follows the module.
`include "sso_defines.svh"

module sso_top_chk (
    // Clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 rst_b_i,
    // Register port
    input  wire logic [7:0]           reg_addr_i,
    input  wire logic [31:0]          reg_wdata_i,
    input  wire logic                 reg_wr_i,
    input  wire logic                 reg_rd_i,
    input  wire logic [31:0]          reg_rdata_o,
    // Status and outputs
    input  wire sso_pkg::sso_status_t status_i,
    input  wire logic                 ctrl_out_a_o,
    input  wire logic                 ctrl_out_b_o,
    input  wire logic                 ctrl_out_c_o,
    input  wire logic                 irq_o
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [2:0] outs;

    // Output bits in register order, a in bit 0
    assign outs = {ctrl_out_c_o, ctrl_out_b_o, ctrl_out_a_o};

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);

    property p_reset_off;
        $rose(rst_b_i) |-> outs == 3'h0 && !irq_o && reg_rdata_o == 32'h0;
    endproperty
    a_reset_off: assert property (p_reset_off)
        else $error("outputs not off right after reset");

    // Three quiet cycles mean the registered pins cannot move
    property p_stable;
        !reg_wr_i ##1 !reg_wr_i ##1 (!reg_wr_i && $stable(status_i)) |=> $stable(outs);
    endproperty
    a_stable: assert property (p_stable)
        else $error("output moved with no cause");

    property p_mode_none;
        reg_wr_i && reg_addr_i == `SSO_OFS_MODE && reg_wdata_i[1:0] == 2'h3
            |-> ##2 (outs == 3'h0) [*2];
    endproperty
    a_mode_none: assert property (p_mode_none)
        else $error("output on with no active mode");

    property p_rdata_idle;
        !reg_rd_i |=> reg_rdata_o == 32'h0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data without a read");

    property p_unmapped;
        reg_rd_i && (reg_addr_i[1:0] != 2'h0 || reg_addr_i > `SSO_OFS_OUT_STATE)
            |=> reg_rdata_o == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");

    property p_clear_reads0;
        reg_rd_i && reg_addr_i == `SSO_OFS_IRQ_CLEAR |=> reg_rdata_o == 32'h0;
    endproperty
    a_clear_reads0: assert property (p_clear_reads0)
        else $error("clear register read not zero");

    property p_cfg_width;
        reg_rd_i && reg_addr_i >= `SSO_OFS_CFG_BASE && reg_addr_i <= `SSO_OFS_CFG_LAST
            |=> reg_rdata_o[31:5] == 27'h0;
    endproperty
    a_cfg_width: assert property (p_cfg_width)
        else $error("config word upper bits set");

    property p_out_state;
        reg_rd_i && reg_addr_i == `SSO_OFS_OUT_STATE |=> reg_rdata_o[2:0] == $past(outs);
    endproperty
    a_out_state: assert property (p_out_state)
        else $error("output state read differs from pins");

    // A zero enable masks the line from the write edge on
    property p_irq_mask;
        reg_wr_i && reg_addr_i == `SSO_OFS_IRQ_ENABLE && reg_wdata_i[4:0] == 5'h0 |=> !irq_o;
    endproperty
    a_irq_mask: assert property (p_irq_mask)
        else $error("interrupt high with all enables off");
endmodule

bind sso_top sso_top_chk u_chk (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .status_i(status_i), .ctrl_out_a_o(ctrl_out_a_o), .ctrl_out_b_o(ctrl_out_b_o),
    .ctrl_out_c_o(ctrl_out_c_o), .irq_o(irq_o)
);

// file: sim/sso_host_model.sv
// Purpose: Host side of the three open-collector control outputs.
// Assumes: Relay or photocoupler is lit while the transistor is on.
// Notes:   One clock of pick-up delay stands in for the coupler.
module sso_host_model (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_b_i,
    // Transistor states, high is on
    input  wire logic [2:0] xtr_on_i,
    // Levels seen by the host, high is coupler lit
    output logic      [2:0] host_bits_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // Coupler follows the transistor one clock late, dark in reset
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            host_bits_o <= 3'h0;
        end else begin
            host_bits_o <= xtr_on_i;
        end
    end
endmodule

// file: sim/sso_top_tb_top.sv
// Purpose: Self-checking bench of the status output selector.
// Assumes: Read expectations wait in a queue for the monitor.
// Notes:   Expected pins come from a small model kept in the bench.
`include "sso_defines.svh"

module sso_top_tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct packed {
        logic [31:0] mask;
        logic [31:0] exp;
    } sso_note_t;

    logic                 clk_i       = 1'b0;
    logic                 rst_b_i     = 1'b0;
    logic [7:0]           reg_addr_i  = 8'h00;
    logic [31:0]          reg_wdata_i = 32'h0;
    logic                 reg_wr_i    = 1'b0;
    logic                 reg_rd_i    = 1'b0;
    logic [31:0]          reg_rdata_o;
    sso_pkg::sso_status_t st          = '0;
    logic [2:0]           outs;
    logic [2:0]           host_bits;
    logic                 irq_o;
    logic                 rd_q        = 1'b0;
    sso_note_t            notes[$];
    logic [4:0]           cfg_m [9];
    logic [1:0]           mode_m;
    int                   fails           = 0;
    int                   samples_checked = 0;
    int                   cycles          = 0;

    // 20 MHz control clock
    always #25 clk_i = ~clk_i;

    sso_top dut (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .status_i(st), .ctrl_out_a_o(outs[0]),
        .ctrl_out_b_o(outs[1]), .ctrl_out_c_o(outs[2]), .irq_o(irq_o)
    );

    sso_host_model host (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .xtr_on_i(outs), .host_bits_o(host_bits)
    );

    // ------------------------------------------------------------------------
    // Comparison, bus tasks and closing report
    // ------------------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("counts: %0d compared, %0d mismatched", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        reg_wr_i    <= 1'b1;
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        @(posedge clk_i);
        reg_wr_i    <= 1'b0;
    endtask

    // Extra edge lets the monitor compare first
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge clk_i);
        reg_rd_i   <= 1'b1;
        reg_addr_i <= a;
        notes.push_back('{m, e});
        @(posedge clk_i);
        reg_rd_i   <= 1'b0;
        @(posedge clk_i);
    endtask

    // Read data stands only in the cycle after the strobe
    always @(posedge clk_i) begin
        sso_note_t n;
        rd_q <= reg_rd_i;
        if (rd_q) begin
            n = notes.pop_front();
            check(reg_rdata_o & n.mask, n.exp);
        end
    end

    // Hang guard, far above what the tests need
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            finish_test();
        end
    end

    // Reference model of one output pin
    function automatic logic exp_pin(input int o);
        logic [4:0] c;
        logic [2:0] ap;
        logic       raw;
        c = cfg_m[mode_m * 3 + o];
        case (c[3:0])
            4'h1: raw = !st.alarm;
            4'h2: raw = st.power_ok && !st.alarm && st.link_up && st.sync_ok;
            4'h3: raw = st.brake_release;
            4'h4: raw = st.pos_done;
            4'h5: raw = st.speed_arrived;
            4'h6: raw = st.torque_limited;
            4'h7: raw = st.zero_speed;
            4'h8: raw = st.speed_coincident;
            default: raw = 1'b0;
        endcase
        case (c[3:0])
            4'h1, 4'h2, 4'h3, 4'h6, 4'h7: ap = 3'h7;
            4'h4: ap = 3'h1;
            4'h5, 4'h8: ap = 3'h2;
            default: ap = 3'h0;
        endcase
        return (mode_m != 2'h3 && ap[mode_m]) ? raw ^ c[4] : 1'b0;
    endfunction

    // Brake release present in some modes but not all
    function automatic logic exp_berr();
        logic [2:0] b;
        for (int m = 0; m < 3; m++)
            b[m] = cfg_m[m * 3][3:0] == 4'h3 || cfg_m[m * 3 + 1][3:0] == 4'h3
                   || cfg_m[m * 3 + 2][3:0] == 4'h3;
        return |b && !(&b);
    endfunction

    // Pins, host view and state register after status has settled
    task automatic pins_check();
        logic [2:0] e;
        repeat (3) @(posedge clk_i);
        e = {exp_pin(2), exp_pin(1), exp_pin(0)};
        check({29'h0, outs}, {29'h0, e});
        check({29'h0, host_bits}, {29'h0, e});
        rd(`SSO_OFS_OUT_STATE, 32'hF, {28'h0, exp_berr(), e});
    endtask

    // Main sequence
    initial begin
        void'($urandom(90712));
        for (int k = 0; k < 9; k++)
            cfg_m[k] = 5'(k % 3 + 1);
        mode_m = 2'h0;
        repeat (10) @(posedge clk_i);
        rst_b_i <= 1'b1;
        rd(`SSO_OFS_MODE, 32'hFFFFFFFF, 32'h0);
        for (int k = 0; k < 9; k++)
            rd(8'(`SSO_OFS_CFG_BASE + 4 * k), 32'hFFFFFFFF, {27'h0, cfg_m[k]});
        rd(`SSO_OFS_IRQ_ENABLE, 32'hFFFFFFFF, 32'h0);
        rd(`SSO_OFS_IRQ_CLEAR, 32'hFFFFFFFF, 32'h0);
        rd(8'h38, 32'hFFFFFFFF, 32'h0);
        rd(8'h05, 32'hFFFFFFFF, 32'h0);
        $display("test reset_values done");
        // Function codes 1 to 8 and the invalid code 9, in every mode
        for (int f = 1; f < 10; f++)
            for (int m = 0; m < 3; m++) begin
                int k;
                k = m * 3 + (f + m) % 3;
                cfg_m[k] = {1'($urandom), 4'(f)};
                mode_m = 2'(m);
                wr(8'(`SSO_OFS_CFG_BASE + 4 * k), {27'h0, cfg_m[k]});
                wr(`SSO_OFS_MODE, {30'h0, mode_m});
                st <= sso_pkg::sso_status_t'(10'($urandom));
                pins_check();
            end
        $display("test function_sweep done");
        // Brake release missing in torque mode, then no active mode
        for (int m = 0; m < 3; m++) begin
            cfg_m[m * 3 + 2] = (m == 2) ? 5'h00 : 5'h03;
            wr(8'(`SSO_OFS_CFG_BASE + 4 * (m * 3 + 2)), {27'h0, cfg_m[m * 3 + 2]});
        end
        wr(`SSO_OFS_MODE, 32'h3);
        mode_m = 2'h3;
        pins_check();
        $display("test brake_and_mode_none done");
        // Alarm rising edge raised, masked, unmasked, cleared
        st <= '0;
        wr(`SSO_OFS_IRQ_CLEAR, 32'h1F);
        wr(`SSO_OFS_IRQ_ENABLE, 32'h8);
        st.alarm <= 1'b1;
        repeat (3) @(posedge clk_i);
        check({31'h0, irq_o}, 32'h1);
        rd(`SSO_OFS_IRQ_STATUS, 32'h8, 32'h8);
        wr(`SSO_OFS_IRQ_ENABLE, 32'h0);
        @(posedge clk_i);
        check({31'h0, irq_o}, 32'h0);
        wr(`SSO_OFS_IRQ_ENABLE, 32'h8);
        @(posedge clk_i);
        check({31'h0, irq_o}, 32'h1);
        wr(`SSO_OFS_IRQ_CLEAR, 32'h8);
        @(posedge clk_i);
        check({31'h0, irq_o}, 32'h0);
        rd(`SSO_OFS_IRQ_STATUS, 32'h8, 32'h0);
        $display("test alarm_interrupt done");
        finish_test();
    end
endmodule
